// ---- src/vca_ctrl.sv ----
/*
  Oscillator core/band/bias selection with manual override, double buffer,
  autocalibration sequencer and a fast-calibration look-up table.
  Assumes a synchronous register port and an analog side that returns a
  calibration result (CAL_RESULT) and the reference, N-divider and ADC clocks.
*/
// The plain strobed port and the address map are this design's own decisions.
`include "vco_cal_regs.svh"
`default_nettype none

// Summary of operation
// - With double buffer set, manual values wait in a shadow stage.
// - Writing the integer divider word commits pending manual values.
// - Core override flag selects core from manual core field.
// - Band override flag selects band from manual band field.
// - Bias override flag selects bias from manual bias field.
// - Clearing a calibration clock enable gates that clock from the logic.
// - N-clock mute blocks the N-divider clock to the phase detector.
// - Fast calibration table holds 32 core, band, bias entries.
// - Fast calibration start runs 32 autocalibrations, filling the table.
// - Later frequency changes interpolate between stored table entries.
// - Divider write with autocalibration enabled launches autocalibration while idle and before the table is filled.
// - Busy bits: ADC busy falls first, then sequencer busy.
module vca_ctrl #(
  parameter int LUT_DEPTH = `VCA_LUT_DEPTH
) (
  input  wire logic                     CORE_CLK,
  input  wire logic                     SYS_RST,
  input  wire logic [`VCA_ADDR_W-1:0]   REG_ADDR,
  input  wire logic [`VCA_DATA_W-1:0]   REG_WDATA,
  input  wire logic                     REG_WR,
  input  wire logic                     REG_RD,
  output logic      [`VCA_DATA_W-1:0]   REG_RDATA,
  input  wire vca_pkg::vca_set_s        CAL_RESULT,
  input  wire logic                     REF_DIV_CLK_IN,
  input  wire logic                     N_DIV_CLK_IN,
  input  wire logic                     ADC_CLK_IN,
  output logic                          REF_DIV_CLK_GATED,
  output logic                          N_DIVIDED_CLOCK_GATED,
  output logic                          ADC_CLK_GATED,
  output logic                          PFD_N_CLK,
  output vca_pkg::vca_set_s             OSC_SETTING,
  output logic                          CAL_SEQUENCER_BUSY
);
  import vca_pkg::*;

  localparam int IW = $clog2(LUT_DEPTH);

  vca_state_e   state_ff, nxt_state;
  logic [7:0]   ovr_ff, cal_ctrl_ff, clk_ctrl_ff, ndiv_ff;
  vca_set_s     shadow_ff, active_ff, cal_ff, out_ff;
  vca_set_s     lut_ff [LUT_DEPTH];
  logic [7:0]   cnt_ff, nxt_cnt;
  logic [IW-1:0] idx_ff;
  logic         fill_ff, lut_valid_ff;
  logic         adc_busy_ff, cal_sequencer_busy_ff;
  logic [7:0]   rdata_ff;
  logic         rg_ff, ng_ff, ag_ff, pn_ff;

  wire wr_ndiv  = REG_WR && (REG_ADDR == `VCA_OFS_NDIV_INT);
  wire wr_core  = REG_WR && (REG_ADDR == `VCA_OFS_MAN_CORE);
  wire wr_band  = REG_WR && (REG_ADDR == `VCA_OFS_MAN_BAND);
  wire wr_bias  = REG_WR && (REG_ADDR == `VCA_OFS_MAN_BIAS);
  wire db_on    = ovr_ff[`VCA_BIT_OVR_DB];
  wire autocal  = cal_ctrl_ff[`VCA_BIT_AUTOCAL];
  wire fast_go  = REG_WR && (REG_ADDR == `VCA_OFS_CAL_CTRL)
                  && REG_WDATA[`VCA_BIT_FASTCAL_GO];
  // Divider write launches calibration only when enabled
  wire cal_launch = wr_ndiv && autocal && (state_ff == ST_IDLE) && !lut_valid_ff;
  // After table fill, divider write interpolates instead
  wire interp_go  = wr_ndiv && autocal && lut_valid_ff;

  // Upper divider bits pick the table slot, the lowest bit blends neighbours
  wire [IW-1:0] lo_idx = ndiv_nxt_idx(REG_WDATA);
  wire [IW-1:0] hi_idx = (lo_idx == IW'(LUT_DEPTH - 1)) ? lo_idx : lo_idx + IW'(1);
  wire vca_set_s interp = blend(lut_ff[lo_idx], lut_ff[hi_idx], REG_WDATA[0]);

  function automatic logic [IW-1:0] ndiv_nxt_idx(input logic [7:0] n);
    ndiv_nxt_idx = n[IW:1];
  endfunction : ndiv_nxt_idx

  function automatic vca_set_s blend(input vca_set_s a, input vca_set_s b,
                                     input logic half);
    logic [8:0] sb;
    logic [8:0] sv;
    sb = {1'b0, a.band} + {1'b0, b.band};
    sv = {1'b0, a.bias} + {1'b0, b.bias};
    blend.core = half ? b.core : a.core;
    blend.band = half ? sb[8:1] : a.band;
    blend.bias = half ? sv[8:1] : a.bias;
  endfunction : blend

  // Sequencer: ADC phase, then tail phase
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (fast_go)
        begin
          nxt_state = ST_ADC;
          nxt_cnt   = `VCA_ADC_CYCLES;
        end
        else if (cal_launch)
        begin
          nxt_state = ST_ADC;
          nxt_cnt   = `VCA_ADC_CYCLES;
        end
      end
      ST_ADC:
      begin
        nxt_cnt = cnt_ff - 8'h01;
        if (cnt_ff == 8'h01)
        begin
          nxt_state = ST_TAIL;
          nxt_cnt   = `VCA_FSM_TAIL_CYCLES;
        end
      end
      ST_TAIL:
      begin
        nxt_cnt = cnt_ff - 8'h01;
        if (cnt_ff == 8'h01)
          nxt_state = fill_ff ? ST_FAST : ST_IDLE;
      end
      ST_FAST:
      begin
        if (idx_ff == IW'(LUT_DEPTH - 1))
          nxt_state = ST_IDLE;
        else
        begin
          nxt_state = ST_ADC;
          nxt_cnt   = `VCA_ADC_CYCLES;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ADC busy drops before sequencer busy
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      adc_busy_ff <= 1'b0;
      cal_sequencer_busy_ff <= 1'b0;
    end
    else
    begin
      adc_busy_ff <= (nxt_state == ST_ADC);
      cal_sequencer_busy_ff <= (nxt_state != ST_IDLE);
    end
  end

  // Fast-calibration fill pointer and table storage
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      idx_ff       <= '0;
      fill_ff      <= 1'b0;
      lut_valid_ff <= 1'b0;
    end
    else if (state_ff == ST_IDLE && fast_go)
    begin
      idx_ff       <= '0;
      fill_ff      <= 1'b1;
      lut_valid_ff <= 1'b0;
    end
    else if (state_ff == ST_FAST)
    begin
      idx_ff       <= idx_ff + IW'(1);
      fill_ff      <= (idx_ff != IW'(LUT_DEPTH - 1));
      lut_valid_ff <= (idx_ff == IW'(LUT_DEPTH - 1));
    end
  end

  // Table written from each calibration result during fast-calibration fill
  always_ff @(posedge CORE_CLK)
  begin
    if (state_ff == ST_TAIL && cnt_ff == 8'h01 && fill_ff)
      lut_ff[idx_ff] <= CAL_RESULT;
  end

  // Control registers and calibration result capture
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ovr_ff      <= 8'h00;
      cal_ctrl_ff <= `VCA_RST_CAL_CTRL;
      clk_ctrl_ff <= `VCA_RST_CLK_CTRL;
      ndiv_ff     <= 8'h00;
      cal_ff      <= '0;
    end
    else
    begin
      if (REG_WR && REG_ADDR == `VCA_OFS_OVR_CTRL)
        ovr_ff <= REG_WDATA;
      if (REG_WR && REG_ADDR == `VCA_OFS_CAL_CTRL)
        cal_ctrl_ff <= {7'h00, REG_WDATA[`VCA_BIT_AUTOCAL]};
      if (REG_WR && REG_ADDR == `VCA_OFS_CLK_CTRL)
        clk_ctrl_ff <= REG_WDATA;
      if (wr_ndiv)
        ndiv_ff <= REG_WDATA;
      if (state_ff == ST_TAIL && cnt_ff == 8'h01)
        cal_ff <= CAL_RESULT;
      else if (interp_go)
        cal_ff <= interp;
    end
  end

  // Shadow stage always takes writes; live copy follows it unless buffered
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      shadow_ff <= '0;
      active_ff <= '0;
    end
    else
    begin
      if (wr_core)
        shadow_ff.core <= REG_WDATA[0];
      if (wr_band)
        shadow_ff.band <= REG_WDATA;
      if (wr_bias)
        shadow_ff.bias <= REG_WDATA;
      // Divider write commits, whether or not calibration runs
      if (wr_ndiv || !db_on)
        active_ff <= shadow_ff;
    end
  end

  wire vca_set_s sel = '{
    core: ovr_ff[`VCA_BIT_OVR_CORE] ? active_ff.core : cal_ff.core,
    band: ovr_ff[`VCA_BIT_OVR_BAND] ? active_ff.band : cal_ff.band,
    bias: ovr_ff[`VCA_BIT_OVR_BIAS] ? active_ff.bias : cal_ff.bias
  };

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      out_ff <= '0;
    else
      out_ff <= sel;
  end

  // Clock gating registered on the core clock
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rg_ff <= 1'b0;
      ng_ff <= 1'b0;
      ag_ff <= 1'b0;
      pn_ff <= 1'b0;
    end
    else
    begin
      rg_ff <= REF_DIV_CLK_IN & clk_ctrl_ff[`VCA_BIT_CLK_REF];
      ng_ff <= N_DIV_CLK_IN & clk_ctrl_ff[`VCA_BIT_CLK_NDIV];
      ag_ff <= ADC_CLK_IN & clk_ctrl_ff[`VCA_BIT_CLK_ADC];
      pn_ff <= N_DIV_CLK_IN & ~clk_ctrl_ff[`VCA_BIT_NCLK_MUTE];
    end
  end

  // Read mux, data valid the cycle after the strobe
  wire [7:0] rd_mux =
    (REG_ADDR == `VCA_OFS_NDIV_INT) ? ndiv_ff :
    (REG_ADDR == `VCA_OFS_OVR_CTRL) ? ovr_ff :
    (REG_ADDR == `VCA_OFS_MAN_CORE) ? {7'h00, shadow_ff.core} :
    (REG_ADDR == `VCA_OFS_MAN_BAND) ? shadow_ff.band :
    (REG_ADDR == `VCA_OFS_MAN_BIAS) ? shadow_ff.bias :
    (REG_ADDR == `VCA_OFS_CAL_CTRL) ? cal_ctrl_ff :
    (REG_ADDR == `VCA_OFS_CLK_CTRL) ? clk_ctrl_ff :
    (REG_ADDR == `VCA_OFS_STATUS)   ? {5'h00, adc_busy_ff, cal_sequencer_busy_ff, lut_valid_ff} :
    (REG_ADDR == `VCA_OFS_CORE_RB)  ? {7'h00, cal_ff.core} :
    (REG_ADDR == `VCA_OFS_BAND_RB)  ? cal_ff.band :
    (REG_ADDR == `VCA_OFS_BIAS0_RB) ? (cal_ff.core ? 8'h00 : cal_ff.bias) :
    (REG_ADDR == `VCA_OFS_BIAS1_RB) ? (cal_ff.core ? cal_ff.bias : 8'h00) :
    (REG_ADDR == `VCA_OFS_LUT_PTR)  ? 8'(idx_ff) : 8'h00;

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= REG_RD ? rd_mux : 8'h00;
  end

  assign REG_RDATA             = rdata_ff;
  assign OSC_SETTING           = out_ff;
  assign CAL_SEQUENCER_BUSY    = cal_sequencer_busy_ff;
  assign REF_DIV_CLK_GATED     = rg_ff;
  assign N_DIVIDED_CLOCK_GATED = ng_ff;
  assign ADC_CLK_GATED         = ag_ff;
  assign PFD_N_CLK             = pn_ff;

  // Launch raises both busy bits next cycle
  property p_launch;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    cal_launch && !fast_go |=> adc_busy_ff && cal_sequencer_busy_ff;
  endproperty
  a_launch: assert property (p_launch) else $error("launch missed");

  property p_nolaunch;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    wr_ndiv && !autocal && state_ff == ST_IDLE && !fast_go |=> !cal_sequencer_busy_ff;
  endproperty
  a_nolaunch: assert property (p_nolaunch) else $error("spurious launch");

  // ADC busy falls while sequencer busy still high
  sequence s_adc_fall;
    $fell(adc_busy_ff);
  endsequence
  property p_order;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    s_adc_fall |-> cal_sequencer_busy_ff;
  endproperty
  a_order: assert property (p_order) else $error("busy order wrong");

  // Commit shows at output two cycles after divider write
  property p_commit;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    wr_ndiv && ovr_ff[`VCA_BIT_OVR_BAND] && !(REG_WR && REG_ADDR == `VCA_OFS_OVR_CTRL)
    |=> ##1 OSC_SETTING.band == $past(shadow_ff.band, 2);
  endproperty
  a_commit: assert property (p_commit) else $error("commit missed");

  // Buffered band holds without divider write
  property p_hold;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    db_on && !wr_ndiv |=> $stable(active_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("shadow leaked");

  property p_core;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    ovr_ff[`VCA_BIT_OVR_CORE] |=> OSC_SETTING.core == $past(active_ff.core);
  endproperty
  a_core: assert property (p_core) else $error("core override");

  // Bias from calibration when not overridden
  property p_bias;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    !ovr_ff[`VCA_BIT_OVR_BIAS] |=> OSC_SETTING.bias == $past(cal_ff.bias);
  endproperty
  a_bias: assert property (p_bias) else $error("bias select");

  property p_mute;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    clk_ctrl_ff[`VCA_BIT_NCLK_MUTE] |=> !PFD_N_CLK;
  endproperty
  a_mute: assert property (p_mute) else $error("mute leak");
endmodule : vca_ctrl

`default_nettype wire

// ---- src/vca_pkg.sv ----
/*
  Types for the oscillator calibration / override controller.
  Assumes the constants header is compiled alongside.
*/
`default_nettype none

package vca_pkg;
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h1,
    ST_ADC  = 4'h2,
    ST_TAIL = 4'h4,
    ST_FAST = 4'h8
  } vca_state_e;

  typedef struct packed
  {
    logic       core;
    logic [7:0] band;
    logic [7:0] bias;
  } vca_set_s;
endpackage : vca_pkg

`default_nettype wire

// ---- src/vco_cal_regs.svh ----
/*
  Register offsets, field positions, reset values and timing counts for the
  oscillator calibration / override controller.
  Assumes a plain address/strobe register port with 8-bit addresses.
*/
`ifndef VCO_CAL_REGS_SVH
`define VCO_CAL_REGS_SVH

`define VCA_ADDR_W          8
`define VCA_DATA_W          8
`define VCA_OFS_NDIV_INT    8'h10
`define VCA_OFS_OVR_CTRL    8'h20
`define VCA_OFS_MAN_CORE    8'h21
`define VCA_OFS_MAN_BAND    8'h22
`define VCA_OFS_MAN_BIAS    8'h23
`define VCA_OFS_CAL_CTRL    8'h24
`define VCA_OFS_CLK_CTRL    8'h25
`define VCA_OFS_STATUS      8'h58
`define VCA_OFS_CORE_RB     8'h59
`define VCA_OFS_BAND_RB     8'h5A
`define VCA_OFS_BIAS0_RB    8'h5B
`define VCA_OFS_BIAS1_RB    8'h5C
`define VCA_OFS_LUT_PTR     8'h5D

`define VCA_BIT_OVR_CORE    0
`define VCA_BIT_OVR_BAND    1
`define VCA_BIT_OVR_BIAS    2
`define VCA_BIT_OVR_DB      3
`define VCA_BIT_AUTOCAL     0
`define VCA_BIT_FASTCAL_GO  1
`define VCA_BIT_CLK_REF     0
`define VCA_BIT_CLK_NDIV    1
`define VCA_BIT_CLK_ADC     2
`define VCA_BIT_NCLK_MUTE   3
`define VCA_BIT_ST_ADC      2
`define VCA_BIT_ST_FSM      1

`define VCA_RST_CAL_CTRL    8'h01
`define VCA_RST_CLK_CTRL    8'h07
`define VCA_LUT_DEPTH       32
`define VCA_ADC_CYCLES      8'h10
`define VCA_FSM_TAIL_CYCLES 8'h04

`endif

// ---- verification/vca_analog_model.sv ----
/*
  Behavioural model of the analog calibrator and divider clock sources.
  Assumes the bench picks which calibration outcome is reported.
*/
`default_nettype none

module vca_analog_model
(
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  input  wire logic [1:0]  RESULT_SEL,
  output vca_pkg::vca_set_s CAL_RESULT,
  output logic             REF_DIV_CLK_IN,
  output logic             N_DIV_CLK_IN,
  output logic             ADC_CLK_IN
);
  timeunit 1ns;
  timeprecision 1ns;
  import vca_pkg::*;

  logic tog_ff;

  // Divider clock levels toggle every core cycle so gating shows both phases
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
    if (SYS_RST)
      tog_ff <= 1'b0;
    else
      tog_ff <= ~tog_ff;

  assign REF_DIV_CLK_IN = tog_ff;
  assign N_DIV_CLK_IN   = tog_ff;
  assign ADC_CLK_IN     = tog_ff;

  // Later drift (2) must not leak past a filled table
  always_comb
    case (RESULT_SEL)
      2'h1:    CAL_RESULT = {1'b1, 8'h7B, 8'h2E};
      2'h2:    CAL_RESULT = {1'b0, 8'h11, 8'h22};
      default: CAL_RESULT = {1'b0, 8'h40, 8'h10};
    endcase
endmodule : vca_analog_model

`default_nettype wire

// ---- verification/vca_ctrl_tb.sv ----
/*
  Self-checking bench for the oscillator calibration / override controller.
  Assumes the package, constants header and analog model are compiled first.
*/
`include "vco_cal_regs.svh"
`default_nettype none

module vca_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import vca_pkg::*;

  typedef struct {logic [7:0] ovr; logic [7:0] clk; vca_set_s exp;} vca_row_s;
  localparam vca_set_s RA = {1'b0, 8'h40, 8'h10};
  localparam vca_set_s RF = {1'b1, 8'h7B, 8'h2E};
  localparam vca_set_s M1 = {1'b1, 8'hA5, 8'h3C};
  localparam vca_set_s M2 = {1'b0, 8'h5C, 8'h81};

  logic       CORE_CLK   = 1'b0;
  logic       SYS_RST    = 1'b1;
  logic [7:0] REG_ADDR   = 8'h00;
  logic [7:0] REG_WDATA  = 8'h00;
  logic       REG_WR     = 1'b0;
  logic       REG_RD     = 1'b0;
  logic [1:0] RESULT_SEL = 2'h0;
  logic [7:0] REG_RDATA;
  vca_set_s   CAL_RESULT;
  vca_set_s   OSC_SETTING;
  logic       REF_DIV_CLK_IN, N_DIV_CLK_IN, ADC_CLK_IN;
  logic       REF_DIV_CLK_GATED, N_DIVIDED_CLOCK_GATED, ADC_CLK_GATED;
  logic       PFD_N_CLK, CAL_SEQUENCER_BUSY;
  int         mismatches = 0;
  int         checks_done = 0;
  vca_row_s   rows [8];
  logic [7:0] idx [3] = '{8'h00, 8'h15, 8'h3E};

  always #50 CORE_CLK = ~CORE_CLK;

  vca_analog_model vca_analog_model_inst (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
    .RESULT_SEL(RESULT_SEL), .CAL_RESULT(CAL_RESULT), .REF_DIV_CLK_IN(REF_DIV_CLK_IN),
    .N_DIV_CLK_IN(N_DIV_CLK_IN), .ADC_CLK_IN(ADC_CLK_IN));

  vca_ctrl vca_ctrl_inst (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .CAL_RESULT(CAL_RESULT), .REF_DIV_CLK_IN(REF_DIV_CLK_IN), .N_DIV_CLK_IN(N_DIV_CLK_IN),
    .ADC_CLK_IN(ADC_CLK_IN), .REF_DIV_CLK_GATED(REF_DIV_CLK_GATED),
    .N_DIVIDED_CLOCK_GATED(N_DIVIDED_CLOCK_GATED), .ADC_CLK_GATED(ADC_CLK_GATED),
    .PFD_N_CLK(PFD_N_CLK), .OSC_SETTING(OSC_SETTING),
    .CAL_SEQUENCER_BUSY(CAL_SEQUENCER_BUSY));

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1;
    d = REG_RDATA;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk({9'h000, d}, {9'h000, e});
  endtask : rdchk

  task automatic final_report();
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  initial
  begin
    #2000000;
    mismatches++;
    final_report();
  end

  initial
  begin
    int         n;
    logic [7:0] st;
    foreach (rows[i])
    begin
      rows[i].ovr = 8'(i);
      rows[i].clk = {4'h0, i[0], ~i[2:0]};
      rows[i].exp = {i[0] ? M1.core : RA.core, i[1] ? M1.band : RA.band,
                     i[2] ? M1.bias : RA.bias};
    end
    repeat (10) @(posedge CORE_CLK);
    #1;
    chk(OSC_SETTING, 17'h00000);
    chk({8'h00, REG_RDATA, CAL_SEQUENCER_BUSY}, 17'h00000);
    repeat (10) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    rdchk(`VCA_OFS_CAL_CTRL, `VCA_RST_CAL_CTRL);
    rdchk(`VCA_OFS_CLK_CTRL, `VCA_RST_CLK_CTRL);
    // First calibration at the target, then readbacks checked
    wr(`VCA_OFS_NDIV_INT, 8'h20);
    rdchk(`VCA_OFS_STATUS, 8'h06);
    repeat (15) @(posedge CORE_CLK);
    rdchk(`VCA_OFS_STATUS, 8'h02);
    n = 0;
    while (CAL_SEQUENCER_BUSY !== 1'b0 && n < 100)
    begin
      @(posedge CORE_CLK);
      n++;
    end
    rdchk(`VCA_OFS_STATUS, 8'h00);
    chk(OSC_SETTING, RA);
    rdchk(`VCA_OFS_CORE_RB, {7'h00, RA.core});
    rdchk(`VCA_OFS_BAND_RB, RA.band);
    rdchk(`VCA_OFS_BIAS0_RB, RA.bias);
    wr(`VCA_OFS_MAN_CORE, {7'h00, M1.core});
    wr(`VCA_OFS_MAN_BAND, M1.band);
    wr(`VCA_OFS_MAN_BIAS, M1.bias);
    foreach (rows[i])
    begin
      wr(`VCA_OFS_OVR_CTRL, rows[i].ovr);
      wr(`VCA_OFS_CLK_CTRL, rows[i].clk);
      repeat (2) @(posedge CORE_CLK);
      chk(OSC_SETTING, rows[i].exp);
      repeat (2)
      begin
        @(negedge CORE_CLK);
        chk({13'h0000, REF_DIV_CLK_GATED, N_DIVIDED_CLOCK_GATED, ADC_CLK_GATED, PFD_N_CLK},
            {13'h0000, ~REF_DIV_CLK_IN & rows[i].clk[0], ~N_DIV_CLK_IN & rows[i].clk[1],
             ~ADC_CLK_IN & rows[i].clk[2], ~N_DIV_CLK_IN & ~rows[i].clk[3]});
      end
    end
    wr(`VCA_OFS_CLK_CTRL, 8'h07);
    wr(`VCA_OFS_CAL_CTRL, 8'h00);
    wr(`VCA_OFS_OVR_CTRL, 8'h0F);
    wr(`VCA_OFS_MAN_CORE, {7'h00, M2.core});
    wr(`VCA_OFS_MAN_BAND, M2.band);
    wr(`VCA_OFS_MAN_BIAS, M2.bias);
    repeat (3) @(posedge CORE_CLK);
    chk(OSC_SETTING, M1);
    wr(`VCA_OFS_NDIV_INT, 8'h21);
    repeat (2) @(posedge CORE_CLK);
    chk(OSC_SETTING, M2);
    chk({16'h0000, CAL_SEQUENCER_BUSY}, 17'h00000);
    // N-clock mute pulse through the clock control register
    wr(`VCA_OFS_CLK_CTRL, 8'h0F);
    @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    chk({16'h0000, PFD_N_CLK}, 17'h00000);
    wr(`VCA_OFS_CLK_CTRL, 8'h07);
    @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    chk({16'h0000, PFD_N_CLK}, {16'h0000, ~N_DIV_CLK_IN});
    wr(`VCA_OFS_OVR_CTRL, 8'h00);
    @(posedge CORE_CLK);
    RESULT_SEL <= 2'h1;
    wr(`VCA_OFS_CAL_CTRL, 8'h03);
    n = 0;
    st = 8'h00;
    while (st[0] !== 1'b1 && n < 600)
    begin
      rd(`VCA_OFS_STATUS, st);
      n++;
    end
    chk({16'h0000, st[0]}, 17'h00001);
    @(posedge CORE_CLK);
    RESULT_SEL <= 2'h2;
    foreach (idx[j])
    begin
      wr(`VCA_OFS_NDIV_INT, idx[j]);
      repeat (3) @(posedge CORE_CLK);
      chk(OSC_SETTING, RF);
    end
    wr(8'h7F, 8'hFF);
    rdchk(8'h7F, 8'h00);
    final_report();
  end
endmodule : vca_ctrl_tb

`default_nettype wire
